/* power_mode_params.svh */
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH
// ==========================================================
// register map (indices on the host register port)
// ==========================================================
`define PM_REG_MODE_IDX      8'h0e
`define PM_REG_SLEEP_IDX     8'h0f
`define PM_REG_PORT_BASE     8'h1d
`define PM_REG_PORT_STRIDE   8'h10
`define PM_REG_STATUS_IDX    8'h10
// ==========================================================
// fields and reset values
// ==========================================================
`define PM_MODE_LSB          3
`define PM_MODE_MSB          4
`define PM_PORT_PD_BIT       3
`define PM_MODE_RESET        8'h00
`define PM_SLEEP_RESET       8'h00
`define PM_PORT_RESET        8'h00
// ==========================================================
// timing
// ==========================================================
`define PM_CLK_HZ            40000000
`define PM_PULSE_NS          120
`define PM_PULSE_PERIOD_HZ   1
`define PM_SLEEP_UNIT_NS     1000000
`endif

/* power_mode_pkg.sv */
// ==========================================================
// shared types
// ==========================================================
package power_mode_pkg;
   // global operating mode, encoded as the two-bit field
   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'h0,
      MODE_ENERGY   = 2'h1,
      MODE_SOFT_PD  = 2'h2,
      MODE_SAVING   = 2'h3
   } op_mode_t;

   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // enables for the gated function blocks
   typedef struct packed {
      logic pll_en;
      logic mac_en;
      logic host_en;
      logic phy_tx_en;
      logic phy_rx_en;
      logic energy_det_en;
   } block_en_t;
endpackage

/* link_pulse_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"
// ==========================================================
// periodic link pulse generator
// ==========================================================
module link_pulse_gen #(
   parameter int PERIOD_CYC = 40000000,
   parameter int WIDTH_CYC  = 4
) (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   input  wire logic run_in,
   output logic      pulse_out
);
   logic [31:0] cnt_r;   // position within the period
   logic [31:0] cnt_nxt;
   logic        pulse_r;
   logic        pulse_nxt;

   // parked on the last count while stopped, so the first pulse is full width
   always_comb begin
      cnt_nxt   = cnt_r;
      pulse_nxt = 1'b0;
      if (!run_in) begin
         cnt_nxt = 32'(PERIOD_CYC - 1);
      end else begin
         cnt_nxt   = (cnt_r >= 32'(PERIOD_CYC - 1)) ? 32'h0 : cnt_r + 32'h1;
         pulse_nxt = (cnt_nxt < 32'(WIDTH_CYC)); // first cycles of each period
      end
   end

   // register only
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r   <= 32'h0;
         pulse_r <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign pulse_out = pulse_r;
endmodule
`default_nettype wire

/* power_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"
// ==========================================================
// power mode controller
// ==========================================================
module power_mode_control
   import power_mode_pkg::*;
#(
   parameter int NUM_PORTS      = 5,
   parameter int CLK_HZ         = `PM_CLK_HZ,
   parameter int SLEEP_UNIT_CYC = (`PM_CLK_HZ / 1000) * (`PM_SLEEP_UNIT_NS / 1000000),
   parameter int PULSE_PER_CYC  = `PM_CLK_HZ / `PM_PULSE_PERIOD_HZ
) (
   input  wire logic                     core_clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     chip_powerdown_n_in,  // active low power-down pin
   input  wire power_mode_pkg::reg_req_t req_in,               // host register access
   input  wire logic [NUM_PORTS-1:0]     cable_energy_in,      // per-port line energy
   input  wire logic [NUM_PORTS-1:0]     autoneg_en_in,        // per-port auto-negotiation on
   input  wire logic [NUM_PORTS-1:0]     link_up_in,           // per-port cable connected
   output logic [7:0]                    rdata_out,
   output logic                          rvalid_out,
   output power_mode_pkg::block_en_t     chip_en_out,          // chip-level enables
   output logic [NUM_PORTS-1:0]          phy_tx_en_out,
   output logic [NUM_PORTS-1:0]          phy_rx_en_out,
   output logic                          link_pulse_out,
   output logic                          traffic_ok_out,       // packets may flow
   output logic                          soft_reset_out        // internal reset pulse
);
   // ==========================================================
   // timing counts
   // ==========================================================
   // least time rounds up
   localparam int PULSE_CYC = ((`PM_PULSE_NS * (CLK_HZ / 1000000)) + 999) / 1000;

   typedef enum {ED_AWAKE, ED_ASLEEP} ed_state_t;

   // ==========================================================
   // decode helpers
   // ==========================================================
   // port index for a port-control address, NUM_PORTS when none
   function automatic int port_of(input logic [7:0] a);
      port_of = NUM_PORTS;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (a == 8'(`PM_REG_PORT_BASE + i * `PM_REG_PORT_STRIDE)) begin
            port_of = i;
         end
      end
   endfunction

   // ==========================================================
   // state
   // ==========================================================
   op_mode_t               mode_r, mode_nxt;             // global mode field
   logic [7:0]             mode_reg_r, mode_reg_nxt;     // rest of mode register
   logic [7:0]             sleep_r, sleep_nxt;           // go-sleep delay
   logic [NUM_PORTS-1:0]   port_pd_r, port_pd_nxt;       // per-port power-down
   ed_state_t              ed_r, ed_nxt;                 // energy detect sub-state
   logic [31:0]            unit_cnt_r, unit_cnt_nxt;     // delay prescaler
   logic [8:0]             idle_cnt_r, idle_cnt_nxt;     // idle time in delay units
   logic                   pd_seen_r, pd_seen_nxt;       // pin was low last cycle
   logic                   srst_r, srst_nxt;             // internal reset pulse
   logic [7:0]             rdata_r, rdata_nxt;
   logic                   rvalid_r, rvalid_nxt;
   block_en_t              chip_en_r, chip_en_nxt;
   logic [NUM_PORTS-1:0]   tx_en_r, tx_en_nxt;
   logic [NUM_PORTS-1:0]   rx_en_r, rx_en_nxt;
   logic                   traffic_r, traffic_nxt;
   logic                   pulse_w;
   logic                   any_energy;
   logic                   host_acc;
   int                     wport;
   int                     rport;

   assign any_energy = |cable_energy_in;
   assign host_acc   = req_in.wr | req_in.rd;

   // ==========================================================
   // register and mode state
   // ==========================================================
   // an internal reset restores defaults; hardware reset does too
   always_comb begin
      mode_nxt     = mode_r;
      mode_reg_nxt = mode_reg_r;
      sleep_nxt    = sleep_r;
      port_pd_nxt  = port_pd_r;
      pd_seen_nxt  = ~chip_powerdown_n_in;
      srst_nxt     = 1'b0;
      rdata_nxt    = rdata_r;
      rvalid_nxt   = 1'b0;
      wport        = port_of(req_in.addr);
      rport        = wport;
      if (!chip_powerdown_n_in) begin
         // whole chip held down while the pin is low
         mode_nxt     = MODE_NORMAL;
         mode_reg_nxt = `PM_MODE_RESET;
         sleep_nxt    = `PM_SLEEP_RESET;
         port_pd_nxt  = '0;
      end else if (pd_seen_r) begin
         srst_nxt = 1'b1;
      end else if (mode_r == MODE_SOFT_PD) begin
         // any access, even a dummy one, wakes and resets
         if (host_acc) begin
            mode_nxt     = MODE_NORMAL;
            mode_reg_nxt = `PM_MODE_RESET;
            sleep_nxt    = `PM_SLEEP_RESET;
            port_pd_nxt  = '0;
            srst_nxt     = 1'b1;
         end
      end else if (mode_r != MODE_ENERGY) begin
         // host interface only alive in normal and saving modes
         if (req_in.wr) begin
            if (req_in.addr == `PM_REG_MODE_IDX) begin
               // new mode applies on the next edge
               mode_nxt     = op_mode_t'(req_in.wdata[`PM_MODE_MSB:`PM_MODE_LSB]);
               mode_reg_nxt = req_in.wdata;
            end else if (req_in.addr == `PM_REG_SLEEP_IDX) begin
               sleep_nxt = req_in.wdata;
            end else if (wport < NUM_PORTS) begin
               port_pd_nxt[wport] = req_in.wdata[`PM_PORT_PD_BIT];
            end
         end
         if (req_in.rd) begin
            rvalid_nxt = 1'b1;
            if (req_in.addr == `PM_REG_MODE_IDX) begin
               rdata_nxt = {mode_reg_r[7:`PM_MODE_MSB+1], mode_r, mode_reg_r[`PM_MODE_LSB-1:0]};
            end else if (req_in.addr == `PM_REG_SLEEP_IDX) begin
               rdata_nxt = sleep_r;
            end else if (req_in.addr == `PM_REG_STATUS_IDX) begin
               rdata_nxt = {6'h0, ed_r == ED_ASLEEP, traffic_r};
            end else if (rport < NUM_PORTS) begin
               rdata_nxt = 8'(port_pd_r[rport]) << `PM_PORT_PD_BIT;
            end else begin
               rdata_nxt = 8'h00;                             // unmapped reads zero
            end
         end
      end
   end

   // register only
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_r     <= MODE_NORMAL;
         mode_reg_r <= `PM_MODE_RESET;
         sleep_r    <= `PM_SLEEP_RESET;
         port_pd_r  <= '0;
         pd_seen_r  <= 1'b0;
         srst_r     <= 1'b0;
         rdata_r    <= 8'h00;
         rvalid_r   <= 1'b0;
      end else begin
         mode_r     <= mode_nxt;
         mode_reg_r <= mode_reg_nxt;
         sleep_r    <= sleep_nxt;
         port_pd_r  <= port_pd_nxt;
         pd_seen_r  <= pd_seen_nxt;
         srst_r     <= srst_nxt;
         rdata_r    <= rdata_nxt;
         rvalid_r   <= rvalid_nxt;
      end
   end

   // ==========================================================
   // energy detect state machine
   // ==========================================================
   // idle time counted in delay units; strictly greater than delay
   always_comb begin
      ed_nxt       = ed_r;
      unit_cnt_nxt = unit_cnt_r;
      idle_cnt_nxt = idle_cnt_r;
      if (mode_r != MODE_ENERGY || !chip_powerdown_n_in) begin
         ed_nxt       = ED_AWAKE;
         unit_cnt_nxt = 32'h0;
         idle_cnt_nxt = 9'h0;
      end else begin
         case (ed_r)
            ED_AWAKE: begin
               if (any_energy) begin
                  unit_cnt_nxt = 32'h0;
                  idle_cnt_nxt = 9'h0;
               end else if (idle_cnt_r > {1'b0, sleep_r}) begin
                  ed_nxt = ED_ASLEEP;
               end else if (unit_cnt_r >= 32'(SLEEP_UNIT_CYC - 1)) begin
                  unit_cnt_nxt = 32'h0;
                  idle_cnt_nxt = idle_cnt_r + 9'h1;
               end else begin
                  unit_cnt_nxt = unit_cnt_r + 32'h1;
               end
            end
            ED_ASLEEP: begin
               if (any_energy) begin
                  ed_nxt       = ED_AWAKE;
                  unit_cnt_nxt = 32'h0;
                  idle_cnt_nxt = 9'h0;
               end
            end
            default: ed_nxt = ED_AWAKE;
         endcase
      end
   end

   // register only
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ed_r       <= ED_AWAKE;
         unit_cnt_r <= 32'h0;
         idle_cnt_r <= 9'h0;
      end else begin
         ed_r       <= ed_nxt;
         unit_cnt_r <= unit_cnt_nxt;
         idle_cnt_r <= idle_cnt_nxt;
      end
   end

   // ==========================================================
   // block enables
   // ==========================================================
   // one decode per mode; port bits override per port
   always_comb begin
      chip_en_nxt = '0;
      tx_en_nxt   = '0;
      rx_en_nxt   = '0;
      traffic_nxt = 1'b0;
      if (chip_powerdown_n_in) begin
         case (mode_r)
            MODE_NORMAL: begin
               chip_en_nxt = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
               tx_en_nxt   = '1;
               rx_en_nxt   = '1;
               traffic_nxt = 1'b1;
            end
            MODE_SAVING: begin
               chip_en_nxt = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
               tx_en_nxt   = '1;
               // receiver off only for idle autoneg ports
               rx_en_nxt   = ~(autoneg_en_in & ~link_up_in & ~cable_energy_in);
               traffic_nxt = 1'b1;
            end
            MODE_ENERGY: begin
               chip_en_nxt.energy_det_en = 1'b1;
               if (ed_r == ED_AWAKE) begin
                  chip_en_nxt.phy_tx_en = 1'b1;
                  chip_en_nxt.phy_rx_en = 1'b1;
                  tx_en_nxt   = '1;
                  rx_en_nxt   = '1;
                  traffic_nxt = 1'b1;
               end
            end
            MODE_SOFT_PD: begin
               chip_en_nxt = '0;
            end
            default: chip_en_nxt = '0;
         endcase
      end
      tx_en_nxt = tx_en_nxt & ~port_pd_r;
      rx_en_nxt = rx_en_nxt & ~port_pd_r;
   end

   // register only
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         chip_en_r <= '0;
         tx_en_r   <= '0;
         rx_en_r   <= '0;
         traffic_r <= 1'b0;
      end else begin
         chip_en_r <= chip_en_nxt;
         tx_en_r   <= tx_en_nxt;
         rx_en_r   <= rx_en_nxt;
         traffic_r <= traffic_nxt;
      end
   end

   // ==========================================================
   // link pulses in energy detect mode
   // ==========================================================
   // pulses keep running in both energy sub-states
   link_pulse_gen #(
      .PERIOD_CYC (PULSE_PER_CYC),
      .WIDTH_CYC  (PULSE_CYC)
   ) u_pulse (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .run_in      (mode_r == MODE_ENERGY && chip_powerdown_n_in),
      .pulse_out   (pulse_w)
   );

   assign rdata_out      = rdata_r;
   assign rvalid_out     = rvalid_r;
   assign chip_en_out    = chip_en_r;
   assign phy_tx_en_out  = tx_en_r;
   assign phy_rx_en_out  = rx_en_r;
   assign link_pulse_out = pulse_w;
   assign traffic_ok_out = traffic_r;
   assign soft_reset_out = srst_r;
endmodule
`default_nettype wire

/* power_mode_control_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"
// ==========================================================
// power mode checker
// ==========================================================
module power_mode_control_assertions #(
   parameter int NUM_PORTS      = 5,
   parameter int SLEEP_UNIT_CYC = 4,
   parameter int PULSE_PER_CYC  = 64
) (
   input wire logic                      core_clk_in,
   input wire logic                      rst_in,
   input wire logic                      chip_powerdown_n_in,
   input wire power_mode_pkg::reg_req_t  req_in,
   input wire logic [NUM_PORTS-1:0]      cable_energy_in,
   input wire logic [NUM_PORTS-1:0]      autoneg_en_in,
   input wire logic [NUM_PORTS-1:0]      link_up_in,
   input wire logic [7:0]                rdata_out,
   input wire logic                      rvalid_out,
   input wire power_mode_pkg::block_en_t chip_en_out,
   input wire logic [NUM_PORTS-1:0]      phy_tx_en_out,
   input wire logic [NUM_PORTS-1:0]      phy_rx_en_out,
   input wire logic                      link_pulse_out,
   input wire logic                      traffic_ok_out,
   input wire logic                      soft_reset_out
);
   import power_mode_pkg::*;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   // ==========================================================
   // properties
   // ==========================================================
   // an answer needs a read taken while the host side was up
   chk_rvalid_cause: assert property (rvalid_out |-> $past(req_in.rd) && chip_en_out.host_en)
      else $error("read answer without an accepted read");
   // clocks, mac and host side always switch together
   chk_core_tied: assert property (chip_en_out.pll_en == chip_en_out.mac_en && chip_en_out.pll_en == chip_en_out.host_en)
      else $error("pll, mac and host enables disagree");
   // writing energy or soft power-down gates the clocks within two cycles
   chk_mode_write: assert property (req_in.wr && req_in.addr == `PM_REG_MODE_IDX && (req_in.wdata[4] ^ req_in.wdata[3])
      && chip_en_out.host_en && chip_powerdown_n_in |-> ##[1:2] !chip_en_out.pll_en)
      else $error("mode write did not gate the clocks");
   // pin low shuts everything on the next edge
   chk_pin_down: assert property (!chip_powerdown_n_in |=> chip_en_out == '0 && phy_tx_en_out == '0 && phy_rx_en_out == '0)
      else $error("power-down pin did not shut the chip");
   // pin release must be followed by the internal reset pulse
   chk_pin_release: assert property ($rose(chip_powerdown_n_in) |-> ##[1:3] soft_reset_out)
      else $error("no internal reset after pin release");
   // link pulse is five cycles wide; pin low may cut it short
   chk_pulse_width: assert property (@(posedge core_clk_in) disable iff (rst_in || !chip_powerdown_n_in)
      $rose(link_pulse_out) |-> link_pulse_out [*5] ##1 !link_pulse_out)
      else $error("link pulse width wrong");
   // pulses only while the clocks are gated
   chk_pulse_gated: assert property (link_pulse_out |-> !chip_en_out.pll_en)
      else $error("link pulse outside energy mode");
   // line energy in low power wakes the port side quickly
   chk_energy_wake: assert property (!traffic_ok_out && chip_en_out.energy_det_en && !chip_en_out.pll_en
      && cable_energy_in != '0 && chip_powerdown_n_in |-> ##[1:2] traffic_ok_out)
      else $error("energy did not wake the device");
   // internal reset brings the chip back to normal
   chk_soft_wake: assert property (soft_reset_out |-> ##[1:2] (chip_en_out.pll_en && chip_en_out.host_en))
      else $error("internal reset did not restore normal mode");
endmodule
bind power_mode_control power_mode_control_assertions #(.NUM_PORTS(NUM_PORTS), .SLEEP_UNIT_CYC(SLEEP_UNIT_CYC),
   .PULSE_PER_CYC(PULSE_PER_CYC)) u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .chip_powerdown_n_in(chip_powerdown_n_in), .req_in(req_in), .cable_energy_in(cable_energy_in),
   .autoneg_en_in(autoneg_en_in), .link_up_in(link_up_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
   .chip_en_out(chip_en_out), .phy_tx_en_out(phy_tx_en_out), .phy_rx_en_out(phy_rx_en_out),
   .link_pulse_out(link_pulse_out), .traffic_ok_out(traffic_ok_out), .soft_reset_out(soft_reset_out));
`default_nettype wire

/* host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host processor model: register strobes and power-down pin
// ==========================================================
module host_model (
   input  wire logic                core_clk_in,
   output power_mode_pkg::reg_req_t req_out,
   output logic                     pin_n_out
);
   import power_mode_pkg::*;
   // idle bus, pin released high
   initial begin
      req_out = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
      pin_n_out = 1'b1;
   end
   // one-cycle strobe, any mode code may be written
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_in);
      req_out = '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(negedge core_clk_in);
      // stale bus must not look like the last value
      req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // pin changes on falling edges only
   task automatic set_pin(input logic v);
      @(negedge core_clk_in);
      pin_n_out = v;
   endtask
endmodule
`default_nettype wire

/* tb_power_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"
// ==========================================================
// power mode controller bench
// ==========================================================
module tb_power_mode_control;
   import power_mode_pkg::*;
   localparam int         NP     = 5;
   localparam int         UNIT   = 4;                 // short go-sleep unit
   localparam int         PER    = 64;                // short pulse period
   localparam logic [7:0] MODE_A = `PM_REG_MODE_IDX;
   localparam logic [7:0] SLP_A  = `PM_REG_SLEEP_IDX;
   logic          core_clk_in;
   logic          rst_in;
   logic [NP-1:0] energy;
   logic [NP-1:0] autoneg;
   logic [NP-1:0] link_up;
   reg_req_t      req;
   logic          pin_n;
   logic [7:0]    rdata;
   logic          rvalid;
   block_en_t     chip_en;
   logic [NP-1:0] tx_en;
   logic [NP-1:0] rx_en;
   logic          pulse;
   logic          traffic_ok;
   logic          soft_rst;
   int            bad_count;
   int            n_tests;
   logic [7:0]    exp_q[$];                           // expected read answers
   host_model host (.core_clk_in(core_clk_in), .req_out(req), .pin_n_out(pin_n));
   power_mode_control #(.SLEEP_UNIT_CYC(UNIT), .PULSE_PER_CYC(PER)) uut (.core_clk_in(core_clk_in),
      .rst_in(rst_in), .chip_powerdown_n_in(pin_n), .req_in(req), .cable_energy_in(energy),
      .autoneg_en_in(autoneg), .link_up_in(link_up), .rdata_out(rdata), .rvalid_out(rvalid),
      .chip_en_out(chip_en), .phy_tx_en_out(tx_en), .phy_rx_en_out(rx_en), .link_pulse_out(pulse),
      .traffic_ok_out(traffic_ok), .soft_reset_out(soft_rst));
   // ==========================================================
   // clock, checks and helpers
   // ==========================================================
   always #12.5 core_clk_in = ~core_clk_in;
   task automatic chk_lvl(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] rdata expected %h seen %h", exp, got);
      end
   endtask
   // answers are matched in order; a stray answer is an error
   always @(negedge core_clk_in) begin
      if (rvalid === 1'b1) begin
         if (exp_q.size() == 0) chk_lvl("stray rvalid", 8'h00, 8'h01);
         else chk_rd(exp_q.pop_front(), rdata);
      end
   end
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = traffic_ok;
         1: pick = pulse;
         default: pick = soft_rst;
      endcase
   endfunction
   // bounded wait; n returns the cycles spent
   task automatic wait_lvl(input string what, input int s, input logic v, input int lim, output int n);
      n = 0;
      while (pick(s) !== v) begin
         @(negedge core_clk_in);
         n++;
         if (n > lim) begin
            bad_count++;
            $display("[ERR] %s expected %b seen timeout", what, v);
            test_done();
         end
      end
   endtask
   task automatic tend(input string name);
      $display("test %s done, mismatches %0d", name, bad_count);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      int n;
      int d;
      logic [7:0] a;
      core_clk_in = 1'b0;
      rst_in = 1'b1;
      energy = '0;
      autoneg = '1;
      link_up = '1;
      bad_count = 0;
      n_tests = 0;
      d = $urandom(77658);
      repeat (4) @(negedge core_clk_in);
      rst_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
      rd(MODE_A, `PM_MODE_RESET);
      rd(`PM_REG_STATUS_IDX, 8'h01);
      chk_lvl("chip enables", 8'h3f, 8'(chip_en));
      chk_lvl("phy tx", 8'h1f, 8'(tx_en));
      tend("reset");
      // each port powered down alone, then back up
      for (int i = 0; i < NP; i++) begin
         a = `PM_REG_PORT_BASE + `PM_REG_PORT_STRIDE * 8'(i);
         host.access(1'b1, a, 8'h08);
         @(negedge core_clk_in);
         chk_lvl("port tx", 8'h1f & ~(8'h01 << i), 8'(tx_en));
         chk_lvl("port rx", 8'h1f & ~(8'h01 << i), 8'(rx_en));
         rd(a, 8'h08);
         host.access(1'b1, a, 8'h00);
      end
      d = $urandom_range(5, 1);
      host.access(1'b1, SLP_A, 8'(d));
      rd(SLP_A, 8'(d));
      rd(8'h80 + 8'($urandom_range(15, 0)), 8'h00);
      tend("ports");
      // saving: only port 0 is idle with auto-negotiation on
      link_up = 5'h1e;
      host.access(1'b1, MODE_A, 8'h18);
      repeat (2) @(negedge core_clk_in);
      rd(MODE_A, 8'h18);
      chk_lvl("saving core", 8'h38, 8'(chip_en) & 8'h38);
      chk_lvl("saving tx", 8'h1f, 8'(tx_en));
      chk_lvl("saving rx", 8'h1e, 8'(rx_en));
      energy = 5'h01;
      repeat (3) @(negedge core_clk_in);
      chk_lvl("saving rx woken", 8'h1f, 8'(rx_en));
      energy = 5'h00;
      autoneg = 5'h1e;
      repeat (3) @(negedge core_clk_in);
      chk_lvl("saving rx no autoneg", 8'h1f, 8'(rx_en));
      host.access(1'b1, MODE_A, 8'h00);
      autoneg = '1;
      link_up = '0;
      tend("saving");
      // energy detect: pulses, go-sleep, wake
      energy = 5'h01;
      host.access(1'b1, MODE_A, 8'h08);
      repeat (2) @(negedge core_clk_in);
      chk_lvl("energy core", 8'h01, 8'(chip_en) & 8'h39);
      chk_lvl("energy awake", 8'h01, 8'(traffic_ok));
      // the first pulse is already under way here; measure the next one
      wait_lvl("first pulse fall", 1, 1'b0, 16, n);
      wait_lvl("pulse rise", 1, 1'b1, PER + 8, n);
      wait_lvl("pulse fall", 1, 1'b0, 16, n);
      chk_lvl("pulse width", 8'd5, 8'(n));
      wait_lvl("pulse rise", 1, 1'b1, PER + 8, n);
      chk_lvl("pulse gap", 8'(PER - 5), 8'(n));
      energy = 5'h00;
      wait_lvl("sleep", 0, 1'b0, (d + 3) * UNIT, n);
      chk_lvl("sleep not early", 8'h01, 8'(n > d * UNIT));
      chk_lvl("low power", 8'h01, 8'(chip_en) & 8'h39);
      host.access(1'b0, MODE_A, 8'h00);
      energy = 5'h10;
      wait_lvl("wake", 0, 1'b1, 3, n);
      tend("energy");
      // power-down pin leaves energy mode
      host.set_pin(1'b0);
      repeat (2) @(negedge core_clk_in);
      chk_lvl("pin down", 8'h00, 8'(chip_en) | 8'(tx_en) | 8'(rx_en));
      host.set_pin(1'b1);
      wait_lvl("pin reset", 2, 1'b1, 4, n);
      repeat (2) @(negedge core_clk_in);
      rd(MODE_A, `PM_MODE_RESET);
      rd(SLP_A, `PM_SLEEP_RESET);
      tend("pin");
      // soft power-down, woken by a dummy read
      host.access(1'b1, SLP_A, 8'h5a);
      host.access(1'b1, MODE_A, 8'h10);
      repeat (2) @(negedge core_clk_in);
      chk_lvl("soft down", 8'h00, 8'(chip_en) & 8'h3e);
      host.access(1'b0, 8'h80, 8'h00);
      wait_lvl("soft reset", 2, 1'b1, 4, n);
      repeat (2) @(negedge core_clk_in);
      chk_lvl("woken", 8'h3f, 8'(chip_en));
      rd(SLP_A, `PM_SLEEP_RESET);
      repeat (4) @(negedge core_clk_in);
      chk_lvl("pending reads", 8'h00, 8'(exp_q.size()));
      tend("soft");
      test_done();
   end
endmodule
`default_nettype wire
